// file: bp_storm_map.svh
// Summary of operation
// - Backpressure starts and stops like flow control
// - Congest port when received frame's destination busy
// - Send preamble carrier so stations defer
// - Drop carrier briefly after time, reassert quickly
// - Queued frames interrupt carrier and get sent
// - Resume carrier when queue empties, until free
// - Collision: skip back-off, assert carrier immediately
// - Aggressive back-off and no-excessive-drop enable bits
// - Both enables reset cleared, standard behaviour
// - After 16 collisions drop or retry per setting
// - Broadcast goes to all ports except source
// - Global option counts multicast with broadcast
// - Global storm limit, per-port enable bit seven
// - Interval 67 ms at 100M, 670 ms at 10M
// - Clear counter each interval, then count traffic
// - Eleven-bit limit in two fields, reset 0x63
`ifndef BP_STORM_MAP_SVH
`define BP_STORM_MAP_SVH

// Core clock period
`define CLK_PERIOD_NS 40

// Backpressure carrier timing
`define BP_CARRIER_MAX_NS 40000
`define BP_CARRIER_MAX_CYC (`BP_CARRIER_MAX_NS / `CLK_PERIOD_NS)
`define IPG_MIN_NS 960
`define BP_GAP_NS 400
`define BP_GAP_CYC (`BP_GAP_NS / `CLK_PERIOD_NS)

// Storm measurement intervals
`define STORM_IVL_100_MS 67
`define STORM_IVL_10_MS 670
`define STORM_IVL_100_CYC (`STORM_IVL_100_MS * 1000000 / `CLK_PERIOD_NS)
`define STORM_IVL_10_CYC (`STORM_IVL_10_MS * 1000000 / `CLK_PERIOD_NS)

// Collision limit per frame
`define EXC_COL_LIMIT 5'h10

// Configuration selectors
`define CFG_SEL_G1 2'h0
`define CFG_SEL_G2 2'h1
`define CFG_SEL_G3 2'h2
`define CFG_SEL_PORT 2'h3

// Field positions
`define G1_AGGR_BACKOFF_BIT 8
`define G2_NO_EXC_DROP_BIT 3
`define G2_MCAST_STORM_BIT 5
`define G3_LIMIT_LO_MSB 2
`define G3_LIMIT_LO_LSB 0
`define G3_LIMIT_HI_MSB 15
`define G3_LIMIT_HI_LSB 8
`define P_STORM_EN_BIT 7

// Reset values
`define AGGR_BACKOFF_RST 1'b0
`define NO_EXC_DROP_RST 1'b0
`define MCAST_STORM_RST 1'b0
`define STORM_EN_RST 1'b0
`define STORM_LIMIT_RST 11'h063

// Forwarding mask of all three switch ports
`define FWD_ALL 3'h7

`endif

// file: bp_storm_pkg.sv
package bp_storm_pkg;
    // Backpressure sequencer states
    typedef enum logic [1:0] {
        BP_IDLE,
        BP_CARRIER,
        BP_GAP,
        BP_YIELD
    } bp_state_t;

    // Queue word: forward mask, start, end, byte
    localparam int FIFO_WORD_W = 13;
    localparam int FIFO_DEPTH = 16;
endpackage : bp_storm_pkg

// file: bp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bp_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage array
    logic [AW-1:0] wr_ptr;  // Write index
    logic [AW-1:0] rd_ptr;  // Read index
    logic do_wr;
    logic do_rd;

    assign in_ready = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // Storage write, no reset needed on data
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                level <= level + 1'b1;
            end else if (do_rd && !do_wr) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule : bp_fifo
`default_nettype wire

// file: storm_meter.sv
`timescale 1ns/1ps
`default_nettype none
`include "bp_storm_map.svh"
module storm_meter (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [24:0] ivl_len,
    input wire logic [10:0] limit,
    input wire logic hit,
    output logic over,
    output logic [10:0] count
);
    logic [24:0] ivl_timer;  // Cycles left in this interval
    logic ivl_start;  // Interval boundary

    assign ivl_start = (ivl_timer == '0);
    assign over = (count >= limit);

    // Interval timer reloads from the speed-chosen length
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ivl_timer <= '0;
        end else if (ivl_start) begin
            ivl_timer <= ivl_len - 25'h1;
        end else begin
            ivl_timer <= ivl_timer - 25'h1;
        end
    end

    // Counter cleared at each boundary; a hit on the boundary counts in the new one
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count <= '0;
        end else if (ivl_start) begin
            count <= hit ? 11'h001 : 11'h000;
        end else if (hit && count != 11'h7ff) begin
            count <= count + 11'h001;
        end
    end
endmodule : storm_meter
`default_nettype wire

// file: backpressure_storm_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "bp_storm_map.svh"
module backpressure_storm_control
    import bp_storm_pkg::*;
#(
    parameter int PORT_ID = 1,
    parameter logic [24:0] IVL_100_CYC = 25'(`STORM_IVL_100_CYC),
    parameter logic [24:0] IVL_10_CYC = 25'(`STORM_IVL_10_CYC)
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Configuration writes
    input wire logic cfg_we,
    input wire logic [1:0] cfg_sel,
    input wire logic [15:0] cfg_wdata,
    // Port and switch status
    input wire logic half_duplex,
    input wire logic link_100,
    input wire logic dest_busy,
    input wire logic tx_pending,
    input wire logic tx_busy,
    input wire logic tx_start,
    input wire logic tx_done,
    input wire logic phy_col,
    // Receive stream
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_is_bcast,
    input wire logic rx_is_mcast,
    input wire logic [2:0] rx_fwd_mask,
    // Stream toward the switch fabric
    output logic sw_valid,
    input wire logic sw_ready,
    output logic [7:0] sw_data,
    output logic sw_sof,
    output logic sw_eof,
    output logic [2:0] sw_fwd_mask,
    // Flow control and backpressure
    output logic fc_active,
    output logic xoff_req,
    output logic xon_req,
    output logic bp_carrier,
    output logic tx_grant,
    output logic backoff_skip,
    output logic aggr_backoff,
    output logic no_exc_drop,
    output logic exc_col_abort,
    // Storm status
    output logic storm_blocked,
    output logic storm_drop,
    output logic [10:0] storm_count
);
    localparam logic [9:0] CARRIER_MAX = 10'(`BP_CARRIER_MAX_CYC);
    localparam logic [9:0] GAP_LEN = 10'(`BP_GAP_CYC);
    localparam logic [2:0] SRC_BIT = 3'(1 << (PORT_ID - 1));

    // Configuration bits
    logic mcast_storm;  // Multicast counted with broadcast
    logic storm_en;  // This port's storm protection
    logic [10:0] storm_limit;  // Frames allowed per interval

    // Collision pin synchroniser and edge
    logic col_s1;
    logic col_s2;
    logic col_s3;
    logic col_rise;

    // Backpressure sequencer
    bp_state_t state;
    bp_state_t next_state;
    logic [9:0] bp_timer;  // Time spent in carrier or gap
    logic bp_need;  // Half-duplex backpressure required
    logic fc_prev;  // Delayed flow-control state
    logic [4:0] col_count;  // Collisions on the current frame

    // Receive side
    logic drop_frame;  // Rest of frame is discarded
    logic rx_take;  // Word accepted from the source
    logic storm_kind;  // Frame qualifies for storm control
    logic storm_over;  // Interval limit reached
    logic storm_hit;  // Qualifying frame start seen
    logic drop_now;  // This word is discarded
    logic [2:0] word_mask;  // Forward mask for this word
    logic [FIFO_WORD_W-1:0] fifo_in;
    logic [FIFO_WORD_W-1:0] fifo_out;
    logic fifo_in_valid;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;

    // Global control one: aggressive back-off, reset cleared
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            aggr_backoff <= `AGGR_BACKOFF_RST;
        end else if (cfg_we && cfg_sel == `CFG_SEL_G1) begin
            aggr_backoff <= cfg_wdata[`G1_AGGR_BACKOFF_BIT];
        end
    end

    // Global control two: no excessive drop and multicast inclusion
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            no_exc_drop <= `NO_EXC_DROP_RST;
            mcast_storm <= `MCAST_STORM_RST;
        end else if (cfg_we && cfg_sel == `CFG_SEL_G2) begin
            no_exc_drop <= cfg_wdata[`G2_NO_EXC_DROP_BIT];
            mcast_storm <= cfg_wdata[`G2_MCAST_STORM_BIT];
        end
    end

    // Global control three: split eleven-bit storm limit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            storm_limit <= `STORM_LIMIT_RST;
        end else if (cfg_we && cfg_sel == `CFG_SEL_G3) begin
            storm_limit <= {cfg_wdata[`G3_LIMIT_LO_MSB:`G3_LIMIT_LO_LSB],
                            cfg_wdata[`G3_LIMIT_HI_MSB:`G3_LIMIT_HI_LSB]};
        end
    end

    // This port's first control register: storm enable
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            storm_en <= `STORM_EN_RST;
        end else if (cfg_we && cfg_sel == `CFG_SEL_PORT) begin
            storm_en <= cfg_wdata[`P_STORM_EN_BIT];
        end
    end

    // Collision comes from the PHY pin, so it is synchronised first
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            col_s1 <= 1'b0;
            col_s2 <= 1'b0;
            col_s3 <= 1'b0;
        end else begin
            col_s1 <= phy_col;
            col_s2 <= col_s1;
            col_s3 <= col_s2;
        end
    end

    assign col_rise = col_s2 && !col_s3;

    // Congestion flag: set by a received frame whose destination is busy,
    // cleared once that resource frees up; the set takes priority
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fc_active <= 1'b0;
        end else if (rx_take && rx_eof && dest_busy) begin
            fc_active <= 1'b1;
        end else if (!dest_busy) begin
            fc_active <= 1'b0;
        end
    end

    // Pause requests for full duplex follow the same flag
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fc_prev <= 1'b0;
            xoff_req <= 1'b0;
            xon_req <= 1'b0;
        end else begin
            fc_prev <= fc_active;
            xoff_req <= !half_duplex && fc_active && !fc_prev;
            xon_req <= !half_duplex && !fc_active && fc_prev;
        end
    end

    assign bp_need = fc_active && half_duplex;

    // Next state of the carrier sequencer
    always_comb begin
        next_state = state;
        case (state)
            BP_IDLE: begin
                if (bp_need) begin
                    // Own frames first, otherwise jam the medium
                    next_state = tx_pending ? BP_YIELD : BP_CARRIER;
                end
            end
            BP_CARRIER: begin
                if (!bp_need) begin
                    next_state = BP_IDLE;
                end else if (tx_pending && !col_s2) begin
                    next_state = BP_YIELD;
                end else if (bp_timer == CARRIER_MAX - 10'h1) begin
                    next_state = BP_GAP;
                end
            end
            BP_GAP: begin
                // Gap is shorter than the interpacket gap, so nobody starts
                if (bp_timer == GAP_LEN - 10'h1) begin
                    next_state = bp_need ? BP_CARRIER : BP_IDLE;
                end
            end
            BP_YIELD: begin
                if (col_rise) begin
                    next_state = BP_CARRIER;
                end else if (!tx_pending && !tx_busy) begin
                    next_state = bp_need ? BP_CARRIER : BP_IDLE;
                end
            end
            default: begin
                next_state = BP_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= BP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Carrier and gap timer restarts on every state change
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bp_timer <= '0;
        end else if (next_state != state) begin
            bp_timer <= '0;
        end else if (state == BP_CARRIER || state == BP_GAP) begin
            bp_timer <= bp_timer + 10'h1;
        end
    end

    // Medium-side outputs, registered; carrier and grant from the next state, back-off skip from the current state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bp_carrier <= 1'b0;
            tx_grant <= 1'b1;
            backoff_skip <= 1'b0;
        end else begin
            bp_carrier <= (next_state == BP_CARRIER);
            tx_grant <= (next_state == BP_IDLE) || (next_state == BP_YIELD);
            // Back-off is bypassed for any collision while jamming or yielding
            backoff_skip <= col_rise && (state != BP_IDLE);
        end
    end

    // Collisions per frame; either enable keeps the frame alive past the limit,
    // which is what lossless half duplex needs
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            col_count <= '0;
            exc_col_abort <= 1'b0;
        end else begin
            exc_col_abort <= 1'b0;
            if (tx_start || tx_done) begin
                col_count <= '0;
            end else if (col_rise && tx_busy) begin
                if (col_count == `EXC_COL_LIMIT - 5'h1) begin
                    col_count <= '0;
                    exc_col_abort <= !(aggr_backoff || no_exc_drop);
                end else begin
                    col_count <= col_count + 5'h1;
                end
            end
        end
    end

    // Storm qualification and limit check at frame start
    assign storm_kind = rx_is_bcast || (mcast_storm && rx_is_mcast);
    assign rx_take = rx_valid && rx_ready;
    assign storm_hit = rx_take && rx_sof && storm_en && storm_kind;
    assign drop_now = rx_sof ? (storm_en && storm_kind && storm_over) : drop_frame;

    storm_meter u_meter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ivl_len(link_100 ? IVL_100_CYC : IVL_10_CYC),
        .limit(storm_limit),
        .hit(storm_hit && !storm_over),
        .over(storm_over),
        .count(storm_count)
    );

    // Frame drop flag carries the start-of-frame decision to its end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            drop_frame <= 1'b0;
            storm_drop <= 1'b0;
            storm_blocked <= 1'b0;
        end else begin
            storm_drop <= rx_take && rx_sof && drop_now;
            storm_blocked <= storm_en && storm_over;
            if (rx_take && rx_sof) begin
                drop_frame <= drop_now && !rx_eof;
            end else if (rx_take && rx_eof) begin
                drop_frame <= 1'b0;
            end
        end
    end

    // Broadcast goes everywhere but the ingress port
    assign word_mask = rx_is_bcast ? (`FWD_ALL & ~SRC_BIT) : rx_fwd_mask;
    assign fifo_in = {word_mask, rx_sof, rx_eof, rx_data};
    assign fifo_in_valid = rx_take && !drop_now;

    // Ready is registered and drops two words early, so one word of slack stays in the queue
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_ready <= 1'b0;
        end else begin
            rx_ready <= fifo_level < ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - 2);
        end
    end

    bp_fifo #(
        .WIDTH(FIFO_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(fifo_in_valid),
        .in_ready(),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign fifo_out_ready = !sw_valid || sw_ready;

    // Output register toward the fabric; a stalled fabric fills the queue
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sw_valid <= 1'b0;
            sw_data <= 8'h00;
            sw_sof <= 1'b0;
            sw_eof <= 1'b0;
            sw_fwd_mask <= 3'h0;
        end else if (fifo_out_ready) begin
            sw_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                {sw_fwd_mask, sw_sof, sw_eof, sw_data} <= fifo_out;
            end
        end
    end
endmodule : backpressure_storm_control
`default_nettype wire

// file: station_model.sv
`timescale 1ns/1ps
`default_nettype none
// Another station on the shared segment; it starts a burst when told to, unless it senses carrier
module station_model (
    input wire logic clk_sys,
    input wire logic bp_carrier,
    input wire logic mac_tx,
    input wire logic go,
    output logic phy_col,
    output logic [7:0] n_defer
);
    logic [1:0] burst; // Cycles left of our own burst
    initial begin
        burst = 2'h0;
        n_defer = 8'h00;
    end
    // Carrier sense first: a busy medium makes the station hold back
    always @(posedge clk_sys) begin
        if (go && bp_carrier) begin
            n_defer <= n_defer + 8'h01;
        end else if (go) begin
            burst <= 2'h2;
        end else if (burst != 2'h0) begin
            burst <= burst - 2'h1;
        end
    end
    // Collision is only seen while both ends transmit at once
    assign phy_col = (burst != 2'h0) && mac_tx;
endmodule : station_model
`default_nettype wire

// file: bp_storm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bp_storm_monitor (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cfg_we,
    input wire logic [1:0] cfg_sel,
    input wire logic [15:0] cfg_wdata,
    input wire logic half_duplex,
    input wire logic dest_busy,
    input wire logic tx_pending,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_is_bcast,
    input wire logic fc_active,
    input wire logic xoff_req,
    input wire logic xon_req,
    input wire logic bp_carrier,
    input wire logic tx_grant,
    input wire logic aggr_backoff,
    input wire logic no_exc_drop,
    input wire logic exc_col_abort,
    input wire logic storm_blocked,
    input wire logic storm_drop
);
    localparam int CAR_MAX = 1000;
    logic [10:0] car_run; // Length of the current carrier burst
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Count carrier cycles; a stuck sequencer would jabber past the limit
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !bp_carrier) begin
            car_run <= 11'h000;
        end else begin
            car_run <= car_run + 11'h001;
        end
    end
    a_aggr_write: assert property (cfg_we && cfg_sel == 2'h0 |=>
        aggr_backoff == $past(cfg_wdata[8])) else $error("aggressive enable not stored");
    a_nodrop_write: assert property (cfg_we && cfg_sel == 2'h1 |=>
        no_exc_drop == $past(cfg_wdata[3])) else $error("no-drop enable not stored");
    a_congest_set: assert property (rx_valid && rx_ready && rx_eof && dest_busy
        |=> fc_active) else $error("congestion not raised");
    a_xoff_full: assert property ($rose(fc_active) && !half_duplex
        |-> ##[0:1] xoff_req) else $error("pause request missing");
    a_xon_full: assert property ($fell(fc_active) && !half_duplex
        |-> ##[0:1] xon_req) else $error("resume request missing");
    a_half_quiet: assert property (half_duplex && $past(half_duplex)
        |-> !xoff_req && !xon_req) else $error("pause frame in half duplex");
    a_carrier_max: assert property (bp_carrier |-> car_run < CAR_MAX)
        else $error("carrier held too long");
    a_gap_short: assert property ($fell(bp_carrier) && fc_active && !tx_pending
        |-> !bp_carrier [*8] ##[1:3] bp_carrier) else $error("silent gap wrong");
    a_yield_grant: assert property (bp_carrier && tx_pending
        |-> ##[1:3] (!bp_carrier && tx_grant)) else $error("no yield to own frames");
    a_storm_drop: assert property (rx_valid && rx_ready && rx_sof && rx_is_bcast
        && storm_blocked |=> storm_drop) else $error("storm frame not dropped");
    a_exc_policy: assert property (exc_col_abort
        |-> !aggr_backoff && !no_exc_drop) else $error("abort despite retry enable");
    c_storm: cover property (storm_drop);
    c_gap: cover property ($fell(bp_carrier) && fc_active && !tx_pending);
    c_yield: cover property (tx_grant && fc_active && half_duplex);
    c_abort: cover property (exc_col_abort);
endmodule : bp_storm_monitor
bind backpressure_storm_control bp_storm_monitor u_mon (.*);
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys, sys_rst, cfg_we, half_duplex, link_100, dest_busy, tx_pending, tx_busy;
    logic tx_start, tx_done, phy_col, rx_valid, rx_ready, rx_sof, rx_eof, rx_is_bcast;
    logic rx_is_mcast, sw_valid, sw_ready, sw_sof, sw_eof, fc_active, xoff_req, xon_req;
    logic bp_carrier, tx_grant, backoff_skip, aggr_backoff, no_exc_drop, exc_col_abort;
    logic storm_blocked, storm_drop, go;
    logic [1:0] cfg_sel;
    logic [15:0] cfg_wdata;
    logic [7:0] rx_data, sw_data, n_defer;
    logic [2:0] rx_fwd_mask, sw_fwd_mask;
    logic [10:0] storm_count;
    int n_fail, n_checks, cyc, n_drop, n_skip, n_abort, n_xoff, n_xon, k;
    logic [13:0] outq [$]; // Words seen leaving toward the fabric
    // Short intervals keep the run brief
    backpressure_storm_control #(.IVL_100_CYC(25'h00000c8), .IVL_10_CYC(25'h00007d0)) DUT (.*);
    station_model peer (.clk_sys(clk_sys), .bp_carrier(bp_carrier), .mac_tx(tx_busy),
        .go(go), .phy_col(phy_col), .n_defer(n_defer));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Fabric sink, pulse counters and hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (sw_valid === 1'b1 && sw_ready === 1'b1) begin
            outq.push_back({sw_fwd_mask, sw_sof, sw_eof, sw_data});
        end
        n_drop += int'(storm_drop === 1'b1);
        n_skip += int'(backoff_skip === 1'b1);
        n_abort += int'(exc_col_abort === 1'b1);
        n_xoff += int'(xoff_req === 1'b1);
        n_xon += int'(xon_req === 1'b1);
        if (cyc == 30000) begin
            n_fail++;
            summarize();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task cyc_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc_n
    task cfg(input logic [1:0] s, input logic [15:0] d);
        cfg_we <= 1'b1;
        cfg_sel <= s;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_we <= 1'b0;
        @(posedge clk_sys);
    endtask : cfg
    // One word, held until the edge that samples ready high
    task put(input logic [7:0] d, input logic s, input logic e);
        int w;
        rx_valid <= 1'b1;
        rx_data <= d;
        rx_sof <= s;
        rx_eof <= e;
        w = 0;
        do begin
            @(posedge clk_sys);
            w++;
        end while (rx_ready !== 1'b1 && w < 200);
    endtask : put
    task frame(input int len, input logic b, input logic m, input logic [2:0] mk);
        rx_is_bcast <= b;
        rx_is_mcast <= m;
        rx_fwd_mask <= mk;
        for (int i = 0; i < len; i++) put(8'(i + 16), i == 0, i == len - 1);
        rx_valid <= 1'b0;
        @(posedge clk_sys);
    endtask : frame
    // Compare n frames of len bytes each, then empty the sink
    task drain_chk(input int n, input int len, input logic [2:0] mk);
        cyc_n(20);
        chk(16'(outq.size()), 16'(n * len));
        for (int i = 0; i < outq.size(); i++) begin
            chk(16'(outq[i]), {2'h0, mk, i % len == 0, i % len == len - 1, 8'(i % len + 16)});
        end
        outq.delete();
    endtask : drain_chk
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    initial begin
        {sys_rst, link_100, sw_ready} = 3'h7;
        {cfg_we, half_duplex, dest_busy, tx_pending, tx_busy, tx_start, tx_done} = 7'h00;
        {rx_valid, rx_sof, rx_eof, rx_is_bcast, rx_is_mcast, go} = 6'h00;
        cfg_sel = 2'h0;
        cfg_wdata = 16'h0000;
        rx_data = 8'h00;
        rx_fwd_mask = 3'h0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        cyc_n(2);
        chk(aggr_backoff, 1'b0);
        chk(no_exc_drop, 1'b0);
        chk(tx_grant, 1'b1);
        // Storm limit of two frames, port enabled
        cfg(2'h2, 16'h0200);
        cfg(2'h3, 16'h0080);
        frame(1, 1'b1, 1'b0, 3'h7);
        frame(1, 1'b1, 1'b0, 3'h7);
        cyc_n(3);
        frame(1, 1'b1, 1'b0, 3'h7);
        cyc_n(3);
        chk(16'(n_drop), 16'h0001);
        chk(storm_count, 11'h002);
        drain_chk(2, 1, 3'h6);
        cyc_n(200);
        chk(storm_count, 11'h000);
        chk(storm_blocked, 1'b0);
        // Multicast counts only once included
        frame(1, 1'b0, 1'b1, 3'h2);
        cyc_n(3);
        chk(storm_count, 11'h000);
        cfg(2'h1, 16'h0020);
        frame(1, 1'b0, 1'b1, 3'h2);
        cyc_n(3);
        chk(storm_count, 11'h001);
        drain_chk(2, 1, 3'h2);
        // Fill the queue against a stalled fabric, then drain it
        sw_ready <= 1'b0;
        fork
            frame(16, 1'b0, 1'b0, 3'h1);
            begin
                cyc_n(60);
                chk(rx_ready, 1'b0);
                sw_ready <= 1'b1;
            end
        join
        drain_chk(1, 16, 3'h1);
        // Full duplex pause and resume
        dest_busy <= 1'b1;
        frame(2, 1'b0, 1'b0, 3'h2);
        cyc_n(4);
        chk(fc_active, 1'b1);
        chk(16'(n_xoff), 16'h0001);
        dest_busy <= 1'b0;
        cyc_n(4);
        chk(fc_active, 1'b0);
        chk(16'(n_xon), 16'h0001);
        // Half duplex carrier backpressure
        half_duplex <= 1'b1;
        dest_busy <= 1'b1;
        frame(2, 1'b0, 1'b0, 3'h2);
        outq.delete();
        cyc_n(4);
        chk(bp_carrier, 1'b1);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        cyc_n(2);
        chk(n_defer, 8'h01);
        k = 0;
        while (bp_carrier === 1'b1 && k < 1100) begin
            @(posedge clk_sys);
            k++;
        end
        k = 0;
        while (bp_carrier !== 1'b1 && k < 40) begin
            @(posedge clk_sys);
            k++;
        end
        chk(16'(k), 16'h000a);
        tx_pending <= 1'b1;
        cyc_n(4);
        chk({bp_carrier, tx_grant}, 2'h1);
        // Collision while our own frame is out
        {tx_busy, tx_start, tx_pending} <= 3'h6;
        @(posedge clk_sys);
        {tx_start, go} <= 2'h1;
        @(posedge clk_sys);
        go <= 1'b0;
        cyc_n(6);
        chk(16'(n_skip), 16'h0001);
        chk(bp_carrier, 1'b1);
        {tx_busy, tx_done, dest_busy} <= 3'h2;
        @(posedge clk_sys);
        tx_done <= 1'b0;
        cyc_n(4);
        chk({fc_active, bp_carrier}, 2'h0);
        chk(16'(n_xon), 16'h0001);
        // Sixteen collisions on one frame, drop then retry
        cfg(2'h0, 16'h0000);
        cfg(2'h1, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            {tx_busy, tx_start} <= 2'h3;
            @(posedge clk_sys);
            tx_start <= 1'b0;
            repeat (16) begin
                go <= 1'b1;
                @(posedge clk_sys);
                go <= 1'b0;
                cyc_n(6);
            end
            chk(16'(n_abort), 16'h0001);
            cfg(2'h0, 16'h0100);
            chk(aggr_backoff, 1'b1);
        end
        cfg(2'h1, 16'h0008);
        chk(no_exc_drop, 1'b1);
        tx_busy <= 1'b0;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
